// ==== brs_cfg.svh ====
`ifndef BRS_CFG_SVH
`define BRS_CFG_SVH

// register offsets on the host register port
`define BRS_OFS_B3_LIMIT 8'h9A
`define BRS_OFS_B4_LIMIT 8'h9B
`define BRS_OFS_B12_LIMIT 8'h9C
`define BRS_OFS_B2_CONF 8'h9D
`define BRS_OFS_B1_CONF 8'h9E
`define BRS_OFS_B4_CONF 8'h9F
`define BRS_OFS_B3_CONF 8'hA0
`define BRS_OFS_B2_VOLT 8'hA3
`define BRS_OFS_B1_VOLT 8'hA4
`define BRS_OFS_B4_VOLT 8'hA5

// storage slots of the registers
`define BRS_IDX_B3_LIMIT 4'h0
`define BRS_IDX_B4_LIMIT 4'h1
`define BRS_IDX_B12_LIMIT 4'h2
`define BRS_IDX_B2_CONF 4'h3
`define BRS_IDX_B1_CONF 4'h4
`define BRS_IDX_B4_CONF 4'h5
`define BRS_IDX_B3_CONF 4'h6
`define BRS_IDX_B2_VOLT 4'h7
`define BRS_IDX_B1_VOLT 4'h8
`define BRS_IDX_B4_VOLT 4'h9
`define BRS_NREG 10
`define BRS_REG_RESET 8'h00

// field positions
`define BRS_SEL_HI 7
`define BRS_SEL_LO 6
`define BRS_PD_BIT 5
`define BRS_TERM_BIT 4
`define BRS_TREF_BIT 3
`define BRS_SLEEP_BIT 7

// operating-select codes
`define BRS_SEL_BYBIT 2'h0
`define BRS_SEL_PFM 2'h1
`define BRS_SEL_PWM 2'h2
`define BRS_SEL_AUTO 2'h3

// limit law in mA: 1400/200, 1700/100, 700/100
`define BRS_LIM12_BASE 13'h578
`define BRS_LIM12_STEP 13'h0C8
`define BRS_LIM3_BASE 13'h6A4
`define BRS_LIM4_BASE 13'h2BC
`define BRS_LIM34_STEP 13'h064

// voltage law in mV: 300/10, 530/10, 800/20
`define BRS_V12_BASE 12'h12C
`define BRS_V4_BASE 12'h212
`define BRS_V3_BASE 12'h320
`define BRS_V_STEP 12'h00A
`define BRS_V3_STEP 12'h014

`endif

// ==== brs_pkg.sv ====
package brs_pkg;

  // resolved switching mode of a converter
  typedef enum logic [1:0] {BRS_PFM, BRS_PWM, BRS_AUTO} brs_mode_t;

  // settings handed to one analogue stage
  typedef struct packed {
    logic [12:0] limit_ma;
    brs_mode_t   mode;
    logic        pulldown_disable;
    logic [6:0]  volt_code;
    logic [11:0] volt_mv;
  } brs_ctrl_t;

  // one register request from the two-wire front end
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } brs_req_t;

endpackage

// ==== brs_buck_settings.sv ====
`timescale 1ns/1ps
`include "brs_cfg.svh"
// Overview of operation
// - buck3 limit is 1700 plus 100 per step
// - buck4 limit is 700 plus 100 per step
// - shared register: buck2 high, buck1 low, 1400+200n
// - half-current mode halves buck1/buck2 limit
// - select field picks sleep-bit, PFM, PWM, auto
// - A sleep bit acts only when select zero
// - bit 5 keeps pull-down off when disabled
// - buck4 bit 4 enables termination supply mode
// - buck4 bit 3 enables termination reference output
// - buck1/buck2 voltage 0.3 V plus 10 mV steps
// - buck4 voltage 0.53 V plus 10 mV steps
module brs_buck_settings
  import brs_pkg::*;
(
  input  wire logic                  clock,                  // register clock
  input  wire logic                  srst,                   // sync reset
  input  wire logic                  ce,                     // freezes all state when low
  input  wire brs_req_t              req,                    // register request
  output logic [7:0]                 reg_rdata,              // read data
  output logic                       reg_rd_valid,           // read answer strobe
  input  wire logic [3:0]            setting_b_active,       // per converter, 1 = B
  input  wire logic [3:0]            sleep_force_b,          // B sleep bits
  input  wire logic                  buck3_sleep_force_a,    // buck3 A sleep bit
  input  wire logic [6:0]            buck3_voltage_a_code,   // buck3 A code
  input  wire logic [3:0][6:0]       voltage_b_code,         // B codes
  input  wire logic [1:0]            half_current,           // buck1/buck2 half mode
  output brs_ctrl_t [3:0]            conv_ctrl,              // stage settings
  output logic                       buck4_termination_enable,
  output logic                       buck4_termination_ref_enable
);

  // limit law per converter, index 0 is buck1
  localparam logic [12:0] LIM_BASE [4] = '{`BRS_LIM12_BASE, `BRS_LIM12_BASE,
                                           `BRS_LIM3_BASE, `BRS_LIM4_BASE};
  localparam logic [12:0] LIM_STEP [4] = '{`BRS_LIM12_STEP, `BRS_LIM12_STEP,
                                           `BRS_LIM34_STEP, `BRS_LIM34_STEP};
  // voltage law per converter
  localparam logic [11:0] V_BASE [4] = '{`BRS_V12_BASE, `BRS_V12_BASE,
                                         `BRS_V3_BASE, `BRS_V4_BASE};
  localparam logic [11:0] V_STEP [4] = '{`BRS_V_STEP, `BRS_V_STEP,
                                         `BRS_V3_STEP, `BRS_V_STEP};

  // address to {hit, slot}
  function automatic logic [4:0] brs_decode(input logic [7:0] a);
    case (a)
      `BRS_OFS_B3_LIMIT:  brs_decode = {1'b1, `BRS_IDX_B3_LIMIT};
      `BRS_OFS_B4_LIMIT:  brs_decode = {1'b1, `BRS_IDX_B4_LIMIT};
      `BRS_OFS_B12_LIMIT: brs_decode = {1'b1, `BRS_IDX_B12_LIMIT};
      `BRS_OFS_B2_CONF:   brs_decode = {1'b1, `BRS_IDX_B2_CONF};
      `BRS_OFS_B1_CONF:   brs_decode = {1'b1, `BRS_IDX_B1_CONF};
      `BRS_OFS_B4_CONF:   brs_decode = {1'b1, `BRS_IDX_B4_CONF};
      `BRS_OFS_B3_CONF:   brs_decode = {1'b1, `BRS_IDX_B3_CONF};
      `BRS_OFS_B2_VOLT:   brs_decode = {1'b1, `BRS_IDX_B2_VOLT};
      `BRS_OFS_B1_VOLT:   brs_decode = {1'b1, `BRS_IDX_B1_VOLT};
      `BRS_OFS_B4_VOLT:   brs_decode = {1'b1, `BRS_IDX_B4_VOLT};
      default:            brs_decode = 5'h00;
    endcase
  endfunction

  logic [7:0]      regs_q [`BRS_NREG];   // register storage
  logic [7:0]      regs_d [`BRS_NREG];   // next storage
  logic [4:0]      wr_dec;               // decoded write address
  logic [4:0]      rd_dec;               // decoded read address
  logic [7:0]      rdata_q;              // read data flop
  logic [7:0]      rdata_d;
  logic            rvalid_q;             // read strobe flop
  logic            rvalid_d;
  brs_ctrl_t [3:0] ctrl_q;               // stage settings flops
  brs_ctrl_t [3:0] ctrl_d;
  logic            term_q;               // termination mode flop
  logic            term_d;
  logic            tref_q;               // termination reference flop
  logic            tref_d;
  logic [7:0]      conf_w [4];           // config register per converter
  logic [3:0]      lcode_w [4];          // limit code per converter
  logic [3:0]      sleep_a_w;            // A sleep bits
  logic [6:0]      vcode_a_w [4];        // A voltage codes
  logic [3:0]      sleep_w;              // sleep bit of active setting

  // address decode, shared by write and read
  assign wr_dec = brs_decode(req.addr);
  assign rd_dec = brs_decode(req.addr);

  // register write: whole byte kept, reserved bits included
  always_comb
  begin
    regs_d = regs_q;
    if (ce && req.wr && wr_dec[4])
    begin
      regs_d[wr_dec[3:0]] = req.wdata;
    end
  end

  // register storage flops
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      for (int i = 0; i < `BRS_NREG; i++)
      begin
        regs_q[i] <= `BRS_REG_RESET;
      end
    end
    else
    begin
      regs_q <= regs_d;
    end
  end

  // read answer one cycle after the request; unmapped reads give zero
  always_comb
  begin
    rdata_d  = rdata_q;
    rvalid_d = rvalid_q;
    if (ce)
    begin
      rvalid_d = req.rd;
      if (req.rd)
      begin
        // old contents win over a write in the same cycle
        rdata_d = rd_dec[4] ? regs_q[rd_dec[3:0]] : 8'h00;
      end
    end
  end

  // read flops
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // gather fields per converter, index 0 is buck1
  always_comb
  begin
    conf_w[0]    = regs_q[`BRS_IDX_B1_CONF];
    conf_w[1]    = regs_q[`BRS_IDX_B2_CONF];
    conf_w[2]    = regs_q[`BRS_IDX_B3_CONF];
    conf_w[3]    = regs_q[`BRS_IDX_B4_CONF];
    // shared register: buck2 high nibble, buck1 low nibble
    lcode_w[0]   = regs_q[`BRS_IDX_B12_LIMIT][3:0];
    lcode_w[1]   = regs_q[`BRS_IDX_B12_LIMIT][7:4];
    lcode_w[2]   = regs_q[`BRS_IDX_B3_LIMIT][3:0];
    lcode_w[3]   = regs_q[`BRS_IDX_B4_LIMIT][3:0];
    sleep_a_w[0] = regs_q[`BRS_IDX_B1_VOLT][`BRS_SLEEP_BIT];
    sleep_a_w[1] = regs_q[`BRS_IDX_B2_VOLT][`BRS_SLEEP_BIT];
    sleep_a_w[2] = buck3_sleep_force_a;
    sleep_a_w[3] = regs_q[`BRS_IDX_B4_VOLT][`BRS_SLEEP_BIT];
    vcode_a_w[0] = regs_q[`BRS_IDX_B1_VOLT][6:0];
    vcode_a_w[1] = regs_q[`BRS_IDX_B2_VOLT][6:0];
    vcode_a_w[2] = buck3_voltage_a_code;
    vcode_a_w[3] = regs_q[`BRS_IDX_B4_VOLT][6:0];
    // sleep bit of whichever setting is live
    sleep_w      = (setting_b_active & sleep_force_b) | (~setting_b_active & sleep_a_w);
  end

  // stage settings, recomputed every enabled cycle
  always_comb
  begin
    ctrl_d = ctrl_q;
    term_d = term_q;
    tref_d = tref_q;
    if (ce)
    begin
      for (int n = 0; n < 4; n++)
      begin
        // base plus code times step
        ctrl_d[n].limit_ma = LIM_BASE[n] + 13'(lcode_w[n]) * LIM_STEP[n];
        if (n < 2 && half_current[n[0]])
        begin
          ctrl_d[n].limit_ma = ctrl_d[n].limit_ma >> 1;
        end
        // operating select decode
        unique case (conf_w[n][`BRS_SEL_HI:`BRS_SEL_LO])
          `BRS_SEL_BYBIT: ctrl_d[n].mode = sleep_w[n] ? BRS_PFM : BRS_PWM;
          `BRS_SEL_PFM:   ctrl_d[n].mode = BRS_PFM;
          `BRS_SEL_PWM:   ctrl_d[n].mode = BRS_PWM;
          `BRS_SEL_AUTO:  ctrl_d[n].mode = BRS_AUTO;
        endcase
        ctrl_d[n].pulldown_disable = conf_w[n][`BRS_PD_BIT];
        // voltage code of the live setting
        ctrl_d[n].volt_code = setting_b_active[n] ? voltage_b_code[n] : vcode_a_w[n];
        ctrl_d[n].volt_mv = V_BASE[n] + 12'(ctrl_d[n].volt_code) * V_STEP[n];
      end
      term_d = conf_w[3][`BRS_TERM_BIT];
      tref_d = conf_w[3][`BRS_TREF_BIT];
    end
  end

  // stage settings flops
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      ctrl_q <= '0;
      term_q <= 1'b0;
      tref_q <= 1'b0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      term_q <= term_d;
      tref_q <= tref_d;
    end
  end

  // outputs straight from flops
  assign reg_rdata                    = rdata_q;
  assign reg_rd_valid                 = rvalid_q;
  assign conv_ctrl                    = ctrl_q;
  assign buck4_termination_enable     = term_q;
  assign buck4_termination_ref_enable = tref_q;

  // buck3 limit law
  b3_limit_a: assert property (@(posedge clock) disable iff (srst)
    ce |=> conv_ctrl[2].limit_ma == 13'h6A4 + 13'($past(regs_q[`BRS_IDX_B3_LIMIT][3:0])) * 13'h064)
    else $error("buck3 limit wrong");

  // buck4 limit law
  b4_limit_a: assert property (@(posedge clock) disable iff (srst)
    ce |=> conv_ctrl[3].limit_ma == 13'h2BC + 13'($past(regs_q[`BRS_IDX_B4_LIMIT][3:0])) * 13'h064)
    else $error("buck4 limit wrong");

  // buck2 takes the high nibble
  b2_limit_a: assert property (@(posedge clock) disable iff (srst)
    ce && !half_current[1] |=>
      conv_ctrl[1].limit_ma == 13'h578 + 13'($past(regs_q[`BRS_IDX_B12_LIMIT][7:4])) * 13'h0C8)
    else $error("buck2 limit wrong");

  // half-current halves buck1
  half_limit_a: assert property (@(posedge clock) disable iff (srst)
    ce && half_current[0] |=>
      conv_ctrl[0].limit_ma == (13'h578 + 13'($past(regs_q[`BRS_IDX_B12_LIMIT][3:0])) * 13'h0C8) >> 1)
    else $error("half limit wrong");

  // forced modes follow the select field
  forced_mode_a: assert property (@(posedge clock) disable iff (srst)
    ce && regs_q[`BRS_IDX_B3_CONF][7:6] != 2'h0 |=>
      conv_ctrl[2].mode == ($past(regs_q[`BRS_IDX_B3_CONF][7:6]) == 2'h1 ? BRS_PFM :
                            $past(regs_q[`BRS_IDX_B3_CONF][7:6]) == 2'h2 ? BRS_PWM : BRS_AUTO))
    else $error("forced mode wrong");

  // A sleep bit steers mode when select is zero
  sleep_bit_a: assert property (@(posedge clock) disable iff (srst)
    ce && regs_q[`BRS_IDX_B1_CONF][7:6] == 2'h0 && !setting_b_active[0] |=>
      conv_ctrl[0].mode == ($past(regs_q[`BRS_IDX_B1_VOLT][7]) ? BRS_PFM : BRS_PWM))
    else $error("sleep bit mode wrong");

  // pull-down disable follows bit 5
  pulldown_a: assert property (@(posedge clock) disable iff (srst)
    ce |=> conv_ctrl[3].pulldown_disable == $past(regs_q[`BRS_IDX_B4_CONF][5]))
    else $error("pull-down disable wrong");

  // termination mode follows bit 4
  term_mode_a: assert property (@(posedge clock) disable iff (srst)
    ce |=> buck4_termination_enable == $past(regs_q[`BRS_IDX_B4_CONF][4]))
    else $error("termination mode wrong");

  // termination reference follows bit 3
  term_ref_a: assert property (@(posedge clock) disable iff (srst)
    ce |=> buck4_termination_ref_enable == $past(regs_q[`BRS_IDX_B4_CONF][3]))
    else $error("termination reference wrong");

  // buck2 A voltage law
  b2_volt_a: assert property (@(posedge clock) disable iff (srst)
    ce && !setting_b_active[1] |=>
      conv_ctrl[1].volt_mv == 12'h12C + 12'($past(regs_q[`BRS_IDX_B2_VOLT][6:0])) * 12'h00A)
    else $error("buck2 voltage wrong");

  // buck4 A voltage law
  b4_volt_a: assert property (@(posedge clock) disable iff (srst)
    ce && !setting_b_active[3] |=>
      conv_ctrl[3].volt_mv == 12'h212 + 12'($past(regs_q[`BRS_IDX_B4_VOLT][6:0])) * 12'h00A)
    else $error("buck4 voltage wrong");

  // B setting supplies the code
  b_select_a: assert property (@(posedge clock) disable iff (srst)
    ce && setting_b_active[3] |=> conv_ctrl[3].volt_code == $past(voltage_b_code[3]))
    else $error("B code not chosen");

  // any mapped byte, reserved bits too, reads back as written
  read_back_a: assert property (@(posedge clock) disable iff (srst)
    ce && req.wr && wr_dec[4] ##1 !req.wr ##1
      ce && req.rd && !req.wr && req.addr == $past(req.addr, 2)
      |=> reg_rd_valid && reg_rdata == $past(req.wdata, 3))
    else $error("read back mismatch");

endmodule

// ==== brs_host_model.sv ====
`timescale 1ns/1ps
// host side of the register port: one request per call
module brs_host_model
  import brs_pkg::*;
(
  input  wire logic       clock,         // register clock
  input  wire logic [7:0] reg_rdata,     // read data from block
  input  wire logic       reg_rd_valid,  // read answer strobe
  output brs_req_t        req            // request toward block
);
  // idle bus until the first call
  initial req = '0;

  // write: launched after an edge, held over exactly one taking edge
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clock);
    #1;
    req.wr    = 1'b1;
    req.addr  = addr;
    req.wdata = data;
    @(posedge clock);
    #1;
    req = '0;
  endtask

  // read: answer sampled 1 ns after the taking edge
  task automatic read_reg(input logic [7:0] addr, output logic valid, output logic [7:0] data);
    @(posedge clock);
    #1;
    req.rd   = 1'b1;
    req.addr = addr;
    @(posedge clock);
    #1;
    req   = '0;
    valid = reg_rd_valid;
    data  = reg_rdata;
  endtask
endmodule

// ==== tb_brs_buck_settings.sv ====
`timescale 1ns/1ps
`include "brs_cfg.svh"
module tb_brs_buck_settings;
  import brs_pkg::*;
  logic            clock  = 1'b0;          // register clock
  logic            srst   = 1'b1;          // sync reset
  logic            ce     = 1'b1;          // clock enable
  brs_req_t        req;                    // from host model
  logic [7:0]      reg_rdata;              // read data
  logic            reg_rd_valid;           // read strobe
  logic [3:0]      sb_act = '0;            // B setting select
  logic [3:0]      sl_b   = '0;            // B sleep bits
  logic            b3_sl  = 1'b0;          // buck3 A sleep bit
  logic [6:0]      b3_va  = '0;            // buck3 A code
  logic [3:0][6:0] vb     = '0;            // B codes
  logic [1:0]      half   = '0;            // half-current mode
  brs_ctrl_t [3:0] ctrl;                   // stage settings
  logic            term;                   // termination supply
  logic            tref;                   // termination reference
  logic [7:0]      sh [8'h9A:8'hA5];       // shadow registers
  logic [7:0]      ofs [10] = '{`BRS_OFS_B3_LIMIT, `BRS_OFS_B4_LIMIT, `BRS_OFS_B12_LIMIT,
    `BRS_OFS_B2_CONF, `BRS_OFS_B1_CONF, `BRS_OFS_B4_CONF, `BRS_OFS_B3_CONF,
    `BRS_OFS_B2_VOLT, `BRS_OFS_B1_VOLT, `BRS_OFS_B4_VOLT}; // mapped offsets
  integer          seed = 32'h63a622b0;    // fixed seed
  int              bad_count = 0;          // mismatches
  int              samples_checked = 0;    // comparisons
  int              cycles = 0;             // timeout counter
  logic [7:0]      a;                      // random address
  logic [7:0]      d;                      // random data

  // free-running clock
  always #4 clock = ~clock;

  brs_host_model i_host (.clock(clock), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .req(req));

  brs_buck_settings i_dut (
    .clock(clock), .srst(srst), .ce(ce), .req(req), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid), .setting_b_active(sb_act), .sleep_force_b(sl_b),
    .buck3_sleep_force_a(b3_sl), .buck3_voltage_a_code(b3_va), .voltage_b_code(vb),
    .half_current(half), .conv_ctrl(ctrl), .buck4_termination_enable(term),
    .buck4_termination_ref_enable(tref));

  // hang guard
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      bad_count++;
      summarize();
    end
  end

  // address lies in the register map
  function automatic logic mapped(input logic [7:0] ad);
    return (ad >= 8'h9A && ad <= 8'hA0) || (ad >= 8'hA3 && ad <= 8'hA5);
  endfunction

  // expected stage settings of converter n (0 = buck1)
  function automatic brs_ctrl_t expect_ctrl(input int n);
    logic [7:0] cf;
    logic [7:0] vr;
    logic       sl;
    logic [6:0] vc;
    int         lim;
    int         mv;
    brs_ctrl_t  e;
    cf = sh[n == 0 ? 8'h9E : n == 1 ? 8'h9D : n == 2 ? 8'hA0 : 8'h9F];
    vr = n == 0 ? sh[8'hA4] : n == 1 ? sh[8'hA3] : n == 3 ? sh[8'hA5] : {b3_sl, b3_va};
    sl = sb_act[n] ? sl_b[n] : vr[7];
    vc = sb_act[n] ? vb[n] : vr[6:0];
    case (n)
      0: lim = (1400 + 200 * sh[8'h9C][3:0]) >> half[0];
      1: lim = (1400 + 200 * sh[8'h9C][7:4]) >> half[1];
      2: lim = 1700 + 100 * sh[8'h9A][3:0];
      default: lim = 700 + 100 * sh[8'h9B][3:0];
    endcase
    mv = n < 2 ? 300 + 10 * vc : n == 2 ? 800 + 20 * vc : 530 + 10 * vc;
    case (cf[7:6])
      2'h1: e.mode = BRS_PFM;
      2'h2: e.mode = BRS_PWM;
      2'h3: e.mode = BRS_AUTO;
      default: e.mode = sl ? BRS_PFM : BRS_PWM;
    endcase
    e.limit_ma = 13'(lim);
    e.pulldown_disable = cf[5];
    e.volt_code = vc;
    e.volt_mv = 12'(mv);
    return e;
  endfunction

  // compare stage settings
  task automatic check_ctrl(input brs_ctrl_t got, input brs_ctrl_t exp);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // compare bytes and flags
  task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // let a write reach the outputs, then check every stage
  task automatic check_all;
    repeat (3) @(posedge clock);
    #1;
    for (int n = 0; n < 4; n++)
      check_ctrl(ctrl[n], expect_ctrl(n));
    check_val({7'h0, term}, {7'h0, sh[8'h9F][4]});
    check_val({7'h0, tref}, {7'h0, sh[8'h9F][3]});
  endtask

  // write through the host, keep the shadow in step
  task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
    i_host.write_reg(ad, dt);
    if (mapped(ad) && ce === 1'b1)
      sh[ad] = dt;
  endtask

  // read back and compare with the shadow
  task automatic rd_check(input logic [7:0] ad);
    logic       v;
    logic [7:0] got;
    i_host.read_reg(ad, v, got);
    check_val({7'h0, v}, 8'h01);
    check_val(got, mapped(ad) ? sh[ad] : 8'h00);
  endtask

  // fresh random side inputs
  task automatic randomize_inputs;
    sb_act = 4'($random(seed));
    sl_b   = 4'($random(seed));
    b3_sl  = 1'($random(seed));
    b3_va  = 7'($random(seed));
    vb     = 28'($random(seed));
    half   = 2'($random(seed));
  endtask

  // verdict and end of run
  task automatic summarize;
    $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    for (int i = 8'h9A; i <= 8'hA5; i++)
      sh[i] = 8'h00;
    repeat (8) @(posedge clock);
    #1;
    srst = 1'b0;
    check_all;
    foreach (ofs[i])
      rd_check(ofs[i]);
    // every select code with both termination bits set
    for (int s = 0; s < 4; s++)
    begin
      wr(8'h9F, {s[1:0], 6'h18});
      rd_check(8'h9F);
      check_all;
    end
    // top codes of all limits and of the buck1 voltage, halved buck1/buck2 limits
    half = 2'h3;
    wr(8'h9C, 8'hFF);
    wr(8'hA4, 8'hFF);
    wr(8'h9B, 8'hFF);
    wr(8'h9A, 8'hFF);
    check_all;
    // random writes and setting changes
    repeat (80)
    begin
      randomize_inputs;
      a = ofs[$unsigned($random(seed)) % 10];
      d = 8'($random(seed));
      wr(a, d);
      check_all;
      rd_check(a);
    end
    // unmapped place reads zero
    wr(8'hA1, 8'h5A);
    rd_check(8'hA1);
    // frozen clock enable drops the write
    ce = 1'b0;
    wr(8'h9F, 8'hFF);
    ce = 1'b1;
    rd_check(8'h9F);
    summarize;
  end
endmodule
